// >>> inc/spt_pkg.sv
// Package of constants for the shaft position tracker
package spt_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int SPT_ANGLE_W = 15;
  localparam int SPT_TURN_W = 16;
  localparam logic [14:0] SPT_ANGLE_MAX = 15'h7fff;
  localparam logic [14:0] SPT_ANGLE_ZERO = 15'h0000;
  localparam logic [15:0] SPT_TURN_RST = 16'h0000;
  // ----------------------------------------------------------------
  // Index zeroing selections
  // ----------------------------------------------------------------
  localparam logic [1:0] SPT_SEL_INDEX = 2'h1;
  localparam logic [1:0] SPT_SEL_SOFT = 2'h2;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] SPT_REG_CTRL = 4'h0;
  localparam logic [3:0] SPT_REG_ANGLE = 4'h1;
  localparam logic [3:0] SPT_REG_TURNS = 4'h2;
  localparam logic [3:0] SPT_REG_STATUS = 4'h3;
  localparam logic [3:0] SPT_REG_IRQ_STAT = 4'h4;
  localparam logic [3:0] SPT_REG_IRQ_MASK = 4'h5;
  localparam int SPT_CTRL_SEL_LSB = 0;
  localparam int SPT_CTRL_ENC_EN = 2;
  localparam int SPT_CTRL_SOFT_ZERO = 3;
  localparam int SPT_IRQ_W = 3;
  localparam int SPT_IRQ_INDEX = 0;
  localparam int SPT_IRQ_FWD_WRAP = 1;
  localparam int SPT_IRQ_BWD_WRAP = 2;
  localparam logic [1:0] SPT_SEL_RST = 2'h0;
  localparam logic [2:0] SPT_MASK_RST = 3'h0;
endpackage

// >>> rtl/spt_tracker.sv
// Shaft position tracker: quadrature decode, angle, turns and register port
// Overview of operation
// RULE1: Shaft angle is a 15-bit count of 32768 steps per turn.
// RULE2: Angle is zero after reset, so the reset position is the reference.
// RULE3: With selection 1 a detected index pulse zeroes the angle.
// RULE4: With selection 2 index pulses are ignored and a software request zeroes the angle.
// RULE5: Any change of the encoder enable bit zeroes the angle.
// RULE6: A forward wrap from 32767 to 0 increments the signed turn counter.
// RULE7: A backward wrap from 0 to 32767 decrements the signed turn counter.
// RULE8: The index-seen flag is 0 after reset.
// RULE9: The index-seen flag sets only under selection 1 on a detected index pulse.
// RULE10: The index-seen flag tells software the angle is referenced to the index mark; only reset clears it, so soft or enable zeroing leaves it set.
// RULE11: Each decoded encoder count moves the angle one step, wrapping modulo 32768.
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module spt_tracker
  import spt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  input wire logic enc_index_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] a_sync;
    logic [2:0] b_sync;
    logic [2:0] z_sync;
    logic [1:0] index_zero_select;
    logic enc_enable;
    logic [14:0] shaft_angle_count;
    logic [15:0] shaft_turn_count;
    logic index_seen_flag;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [15:0] rdata;
  } spt_state_t;

  spt_state_t cur;
  spt_state_t next_st;

  // Quadrature step: +1, -1 or 0 from previous and current AB
  function automatic logic [1:0] spt_quad(input logic [1:0] prev, input logic [1:0] now);
    logic [3:0] key;
    key = {prev, now};
    case (key)
      4'h1, 4'h7, 4'he, 4'h8: spt_quad = 2'h1;
      4'h2, 4'hb, 4'hd, 4'h4: spt_quad = 2'h3;
      default: spt_quad = 2'h0;
    endcase
  endfunction

  always_comb begin
    logic [1:0] step;
    logic fwd;
    logic bwd;
    logic index_evt;
    logic zero_req;
    logic fwd_wrap;
    logic bwd_wrap;
    logic [2:0] evt;
    step = 2'h0;
    fwd = 1'b0;
    bwd = 1'b0;
    index_evt = 1'b0;
    zero_req = 1'b0;
    fwd_wrap = 1'b0;
    bwd_wrap = 1'b0;
    evt = 3'h0;
    next_st = cur;

    // ----------------------------------------------------------------
    // Pin synchronisers (bit 0 first stage, bit 2 history)
    // ----------------------------------------------------------------
    next_st.a_sync = {cur.a_sync[1:0], enc_a_i};
    next_st.b_sync = {cur.b_sync[1:0], enc_b_i};
    next_st.z_sync = {cur.z_sync[1:0], enc_index_i};

    step = spt_quad({cur.a_sync[2], cur.b_sync[2]}, {cur.a_sync[1], cur.b_sync[1]});
    fwd = cur.enc_enable && (step == 2'h1);
    bwd = cur.enc_enable && (step == 2'h3);
    index_evt = cur.enc_enable && cur.z_sync[1] && !cur.z_sync[2];

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    if (wr_i) begin
      case (addr_i)
        SPT_REG_CTRL: begin
          next_st.index_zero_select = wdata_i[SPT_CTRL_SEL_LSB +: 2];
          next_st.enc_enable = wdata_i[SPT_CTRL_ENC_EN];
          if (wdata_i[SPT_CTRL_ENC_EN] != cur.enc_enable) begin
            zero_req = 1'b1; // RULE5
          end
          if (wdata_i[SPT_CTRL_SOFT_ZERO] && cur.index_zero_select == SPT_SEL_SOFT) begin
            zero_req = 1'b1; // RULE4
          end
        end
        SPT_REG_IRQ_MASK: next_st.irq_mask = wdata_i[SPT_IRQ_W-1:0];
        default: begin
        end
      endcase
    end

    if (index_evt && cur.index_zero_select == SPT_SEL_INDEX) begin
      zero_req = 1'b1; // RULE3
      next_st.index_seen_flag = 1'b1; // RULE9 RULE10
    end

    // ----------------------------------------------------------------
    // Angle and turns
    // ----------------------------------------------------------------
    if (zero_req) begin
      next_st.shaft_angle_count = SPT_ANGLE_ZERO;
    end else if (fwd) begin
      next_st.shaft_angle_count = cur.shaft_angle_count + 15'h0001; // RULE11 RULE1
      fwd_wrap = (cur.shaft_angle_count == SPT_ANGLE_MAX);
    end else if (bwd) begin
      next_st.shaft_angle_count = cur.shaft_angle_count - 15'h0001; // RULE11
      bwd_wrap = (cur.shaft_angle_count == SPT_ANGLE_ZERO);
    end
    if (fwd_wrap) begin
      next_st.shaft_turn_count = cur.shaft_turn_count + 16'h0001; // RULE6
    end else if (bwd_wrap) begin
      next_st.shaft_turn_count = cur.shaft_turn_count - 16'h0001; // RULE7
    end

    // ----------------------------------------------------------------
    // Interrupts: read clears, new event wins
    // ----------------------------------------------------------------
    evt[SPT_IRQ_INDEX] = index_evt;
    evt[SPT_IRQ_FWD_WRAP] = fwd_wrap;
    evt[SPT_IRQ_BWD_WRAP] = bwd_wrap;
    if (rd_i && addr_i == SPT_REG_IRQ_STAT) begin
      next_st.irq_stat = evt;
    end else begin
      next_st.irq_stat = cur.irq_stat | evt;
    end

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    next_st.rdata = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        SPT_REG_CTRL: next_st.rdata = {13'h0000, cur.enc_enable, cur.index_zero_select};
        SPT_REG_ANGLE: next_st.rdata = {1'b0, cur.shaft_angle_count};
        SPT_REG_TURNS: next_st.rdata = cur.shaft_turn_count;
        SPT_REG_STATUS: next_st.rdata = {15'h0000, cur.index_seen_flag}; // RULE10
        SPT_REG_IRQ_STAT: next_st.rdata = {13'h0000, cur.irq_stat};
        SPT_REG_IRQ_MASK: next_st.rdata = {13'h0000, cur.irq_mask};
        default: next_st.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cur.a_sync <= 3'h0;
      cur.b_sync <= 3'h0;
      cur.z_sync <= 3'h0;
      cur.index_zero_select <= SPT_SEL_RST;
      cur.enc_enable <= 1'b0;
      cur.shaft_angle_count <= SPT_ANGLE_ZERO; // RULE2
      cur.shaft_turn_count <= SPT_TURN_RST;
      cur.index_seen_flag <= 1'b0; // RULE8
      cur.irq_stat <= 3'h0;
      cur.irq_mask <= SPT_MASK_RST;
      cur.rdata <= 16'h0000;
    end else begin
      cur <= next_st;
    end
  end

  assign rdata_o = cur.rdata;
  assign irq_o = |(cur.irq_stat & cur.irq_mask);

endmodule
`default_nettype wire

// >>> testbench/spt_encoder_model.sv
// Quadrature encoder model with index output
`timescale 1ns/1ps
`default_nettype none
module spt_encoder_model (
  input wire logic clk_i,
  input wire logic step_i,
  input wire logic dir_i,
  input wire logic idx_i,
  output logic a_o,
  output logic b_o,
  output logic z_o
);
  logic [1:0] ph = 2'h0;
  // Phase order 00 01 11 10 is forward rotation
  assign a_o = ph[1];
  assign b_o = ph[1] ^ ph[0];
  always @(posedge clk_i) begin
    if (step_i) ph <= dir_i ? ph + 2'h1 : ph - 2'h1;
    z_o <= idx_i;
  end
endmodule
`default_nettype wire

// >>> testbench/spt_tracker_assertions.sv
// Port checks for the shaft position tracker
`timescale 1ns/1ps
`default_nettype none
module spt_tracker_assertions
  import spt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  input wire logic enc_index_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [1:0] sel;
  logic en, may, ctl_w, rda, rds;
  assign ctl_w = wr_i && addr_i == SPT_REG_CTRL;
  assign rda = rd_i && addr_i == SPT_REG_ANGLE;
  assign rds = rd_i && addr_i == SPT_REG_STATUS;
  // Control mirror; may marks that index zeroing was ever armed
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sel <= SPT_SEL_RST;
      en <= 1'b0;
      may <= 1'b0;
    end else begin
      if (ctl_w) begin
        sel <= wdata_i[1:0];
        en <= wdata_i[SPT_CTRL_ENC_EN];
      end
      may <= may || (sel == SPT_SEL_INDEX && en);
    end
  end
  idle_read_zero_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data not idle");
  angle_width_a: assert property (rda |=> rdata_o[15] == 1'b0)
    else $error("angle wider than 15 bits");
  reset_angle_a: assert property ($rose(rst_n_i) && rda |=> rdata_o == 16'h0000)
    else $error("angle not zero after reset");
  status_width_a: assert property (rds |=> rdata_o[15:1] == 15'h0000)
    else $error("status spare bits set");
  seen_gate_a: assert property (rds && !may |=> rdata_o[0] == 1'b0)
    else $error("index flag set without index mode");
  disabled_zero_a: assert property (rda && !en |=> rdata_o == 16'h0000)
    else $error("angle moved while disabled");
  soft_zero_a: assert property (ctl_w && wdata_i[3:0] == 4'he && sel == SPT_SEL_SOFT && en
    ##[1:2] rda |=> rdata_o == 16'h0000)
    else $error("soft zero ignored");
  irq_mask_a: assert property (wr_i && addr_i == SPT_REG_IRQ_MASK && wdata_i[2:0] == 3'h0
    |=> ##1 !irq_o)
    else $error("masked interrupt raised");
  cover property (irq_o);
  cover property (rds ##1 rdata_o[0]);
  cover property (ctl_w && wdata_i[SPT_CTRL_SOFT_ZERO]);
endmodule
bind spt_tracker spt_tracker_assertions spt_tracker_assertions_i (.clk_i, .rst_n_i, .enc_a_i,
  .enc_b_i, .enc_index_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o);
`default_nettype wire

// >>> testbench/test_spt_tracker.sv
// Self-checking bench for the shaft position tracker
`timescale 1ns/1ps
`default_nettype none
module test_spt_tracker
  import spt_pkg::*;
;
  logic clk_i = 0, rst_n_i = 0, st = 0, dr = 0, ix = 0, wr = 0, rd = 0, a, b, z, irq;
  logic [3:0] ad = 0;
  logic [15:0] wd = 0, rdt;
  logic [31:0] r = 32'h370d;
  int n_errors = 0, num_checks = 0, cyc = 0, n;
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %0t mismatch", $time); end end
  spt_tracker spt_tracker_i (.clk_i, .rst_n_i, .enc_a_i(a), .enc_b_i(b), .enc_index_i(z),
    .addr_i(ad), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdt), .irq_o(irq));
  spt_encoder_model spt_encoder_model_i (.clk_i, .step_i(st), .dir_i(dr), .idx_i(ix),
    .a_o(a), .b_o(b), .z_o(z));
  initial forever #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (++cyc == 3000) begin n_errors++; test_done(); end
  function automatic logic [15:0] ex(input int p);
    return {1'b0, p[14:0]};
  endfunction
  task automatic wrt(input logic [3:0] x, input logic [15:0] d);
    ad <= x;
    wd <= d;
    wr <= 1;
    @(posedge clk_i);
    wr <= 0;
    // Let one edge pass so a following write never re-raises the strobe in this step
    @(posedge clk_i);
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic rdc(input logic [3:0] x, input logic [15:0] e);
    ad <= x;
    rd <= 1;
    @(posedge clk_i);
    rd <= 0;
    @(negedge clk_i);
    `CHK(rdt, e)
    @(posedge clk_i);
  endtask
  // Steps every fourth cycle; an index rise may ride with a step
  task automatic mv(input int k, input logic d, input logic x);
    repeat (k) begin
      dr <= d;
      st <= 1;
      ix <= x;
      @(posedge clk_i);
      st <= 0;
      ix <= 0;
      repeat (3) @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1;
    rdc(SPT_REG_ANGLE, 16'h0000);
    rdc(SPT_REG_STATUS, 16'h0000);
    wrt(SPT_REG_IRQ_MASK, 16'h0004);
    wrt(SPT_REG_CTRL, 16'h0005);
    mv(1, 0, 0);
    rdc(SPT_REG_ANGLE, 16'h7fff);
    `CHK(irq, 1'b1)
    rdc(SPT_REG_IRQ_STAT, 16'h0004);
    mv(1, 1, 0);
    `CHK(irq, 1'b0)
    rdc(SPT_REG_TURNS, 16'h0000);
    r = lfsr(r);
    n = r[3:0] + 2;
    mv(n, 0, 0);
    rdc(SPT_REG_ANGLE, ex(-n));
    rdc(SPT_REG_TURNS, 16'hffff);
    $display("test done: wrap and random walk");
    mv(1, 1, 1);
    rdc(SPT_REG_ANGLE, 16'h0000);
    rdc(SPT_REG_STATUS, 16'h0001);
    wrt(SPT_REG_CTRL, 16'h0006);
    mv(3, 1, 1);
    rdc(SPT_REG_ANGLE, ex(3));
    wrt(SPT_REG_CTRL, 16'h000e);
    rdc(SPT_REG_ANGLE, 16'h0000);
    wrt(SPT_REG_CTRL, 16'h0002);
    mv(2, 1, 0);
    rdc(SPT_REG_ANGLE, 16'h0000);
    wrt(SPT_REG_IRQ_MASK, 16'h0000);
    rdc(SPT_REG_STATUS, 16'h0001);
    $display("test done: zeroing modes");
    test_done();
  end
endmodule
`default_nettype wire
